/* File: fecs_pkg.sv */
// package for the flash erase command sequencer
// assumes one core clock at 50 mhz; numbers shared by design and tests
package fecs_pkg;
  localparam int ADDR_W = 16;
  localparam int SECT_N = 12;
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'haaa;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_BYP_RST1 = 8'h90;
  localparam logic [7:0] CMD_BYP_RST2 = 8'h00;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_BULK = 8'h10;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] BYTE_PROGRAMMED = 8'h00;
  localparam logic [7:0] BYTE_ERASED = 8'hff;
  localparam int CLK_MHZ = 50;
  localparam int WINDOW_US = 100;
  localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
  localparam int SUSP_MIN_NS = 100;
  localparam int SUSP_MAX_NS = 15000;
  localparam int SUSP_CYC = (SUSP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PHASE_CYC = 8192;
  localparam int MAX_PASSES = 4;
  localparam int STAT_POLL = 7;
  localparam int STAT_TOGGLE = 6;
  localparam int STAT_ERROR = 5;
  localparam int STAT_TIMER = 3;
  typedef enum logic [3:0] {
    ST_READ = 4'h0, ST_C1 = 4'h1, ST_C2 = 4'h2, ST_E1 = 4'h3,
    ST_E2 = 4'h4, ST_E3 = 4'h5, ST_BYP = 4'h6, ST_BYP_PRG = 4'h7,
    ST_BYP_RST = 4'h8, ST_BULK = 4'h9, ST_WIN = 4'ha, ST_SECT = 4'hb,
    ST_SUSP_WAIT = 4'hc, ST_SUSP = 4'hd, ST_PRG = 4'he
  } fecs_state_t;
endpackage

/* File: fecs_sequencer.sv */
// flash erase command sequencer: decodes bus writes, runs erase timing
// assumes bus strobes are synchronous to core_clk; array itself is external
`timescale 1ns/1ps
module fecs_sequencer #(
  parameter int WINDOW_CYCLES = fecs_pkg::WINDOW_CYC,
  parameter int PHASE_CYCLES = fecs_pkg::PHASE_CYC,
  parameter int PASSES = fecs_pkg::MAX_PASSES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [fecs_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] main_sector_select,
  input wire logic [3:0] boot_sector_select,
  input wire logic [7:0] array_rdata,
  input wire logic erase_fail,
  output logic [7:0] bus_rdata,
  output logic busy,
  output logic [fecs_pkg::SECT_N-1:0] sector_erase_mask,
  output logic [fecs_pkg::SECT_N-1:0] sector_invalid,
  output logic array_we,
  output logic [fecs_pkg::ADDR_W-1:0] array_waddr,
  output logic [7:0] array_wdata
);
  import fecs_pkg::*;

  fecs_state_t state;
  fecs_state_t next_state;
  logic [SECT_N-1:0] mask;
  logic [SECT_N-1:0] invalid;
  logic [31:0] timer;
  logic [2:0] pass;
  logic prog_phase;
  logic toggle_flag;
  logic error_flag;
  logic bulk_mode;
  logic [7:0] rdata;

  // sector selects are active high; boot sectors follow main ones
  wire [SECT_N-1:0] sel = {boot_sector_select, main_sector_select};
  wire any_sel = |sel;
  wire [11:0] low_addr = bus_addr[11:0];
  wire is_u1 = low_addr == UNLOCK_ADDR1 && bus_wdata == CMD_UNLOCK1;
  wire is_u2 = low_addr == UNLOCK_ADDR2 && bus_wdata == CMD_UNLOCK2;
  wire at_u1 = low_addr == UNLOCK_ADDR1;
  wire is_susp = bus_wdata == CMD_SUSPEND && any_sel;
  wire is_resume = bus_wdata == CMD_RESUME && any_sel;
  wire is_reset = bus_wdata == CMD_RESET;
  wire is_sect = bus_wdata == CMD_SECTOR && any_sel;
  wire timer_done = timer == 32'd0;
  wire erasing = state == ST_BULK || state == ST_WIN || state == ST_SECT ||
    state == ST_SUSP_WAIT;
  wire hit = |(sel & mask);
  wire status_read = erasing && (hit || bulk_mode);
  wire susp_read = state == ST_SUSP && hit;
  wire [7:0] status_byte = {1'b0, toggle_flag, error_flag, 1'b0,
    state != ST_WIN, 3'b000};

  always_comb begin
    next_state = state;
    if (bus_wr) begin
      case (state)
        ST_READ: if (is_u1) next_state = ST_C1;
        ST_C1: next_state = is_u2 ? ST_C2 : ST_READ;
        ST_C2: begin
          if (at_u1 && bus_wdata == CMD_BYPASS) next_state = ST_BYP;
          else if (at_u1 && bus_wdata == CMD_ERASE_SETUP) next_state = ST_E1;
          else if (at_u1 && bus_wdata == CMD_PROGRAM) next_state = ST_BYP_PRG;
          else next_state = ST_READ;
        end
        ST_E1: next_state = is_u1 ? ST_E2 : ST_READ;
        ST_E2: next_state = is_u2 ? ST_E3 : ST_READ;
        ST_E3: begin
          if (at_u1 && bus_wdata == CMD_BULK) next_state = ST_BULK;
          else if (is_sect) next_state = ST_WIN;
          else next_state = ST_READ;
        end
        ST_BYP: begin
          if (bus_wdata == CMD_PROGRAM) next_state = ST_BYP_PRG;
          else if (bus_wdata == CMD_BYP_RST1) next_state = ST_BYP_RST;
          else next_state = ST_BYP;
        end
        ST_BYP_PRG: next_state = ST_PRG;
        ST_BYP_RST: begin
          if (bus_wdata == CMD_BYP_RST2) next_state = ST_READ;
          else next_state = ST_BYP;
        end
        // a write leaves a bulk erase only when it failed, by the reset command
        ST_BULK: next_state = (error_flag && is_reset) ? ST_READ : ST_BULK;
        ST_WIN: begin
          if (is_sect) next_state = ST_WIN;
          else if (is_susp) next_state = ST_SUSP_WAIT;
          else if (is_resume) next_state = ST_WIN;
          else next_state = ST_READ;
        end
        ST_SECT: begin
          if (is_susp) next_state = ST_SUSP_WAIT;
          else if (is_reset) next_state = ST_READ;
          else next_state = ST_SECT;
        end
        ST_SUSP: begin
          if (is_resume) next_state = ST_SECT;
          else if (is_reset) next_state = ST_READ;
          else next_state = ST_SUSP;
        end
        default: next_state = state;
      endcase
    end else begin
      case (state)
        ST_WIN: if (timer_done) next_state = ST_SECT;
        ST_SUSP_WAIT: if (timer_done) next_state = ST_SUSP;
        ST_PRG: next_state = bulk_mode ? ST_READ : ST_BYP;
        // a failed erase holds its status until a reset command
        ST_BULK, ST_SECT: begin
          if (timer_done && !prog_phase && !erase_fail && !error_flag)
            next_state = ST_READ;
        end
        default: next_state = state;
      endcase
    end
  end

  // one status bit change per read: the toggle moves only on status reads
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_flag <= 1'b0;
    end else if (bus_rd && status_read) begin
      toggle_flag <= ~toggle_flag;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_READ;
      mask <= '0;
      invalid <= '0;
      timer <= 32'd0;
      pass <= 3'd0;
      prog_phase <= 1'b0;
      error_flag <= 1'b0;
      bulk_mode <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state == ST_BULK && state != ST_BULK) begin
        mask <= '1;
        bulk_mode <= 1'b1;
        prog_phase <= 1'b1;
        pass <= 3'd0;
        error_flag <= 1'b0;
        timer <= 32'(PHASE_CYCLES);
      end else if (bus_wr && is_sect && (state == ST_E3 || state == ST_WIN)) begin
        if (state == ST_E3) begin
          mask <= sel;
          error_flag <= 1'b0;
          bulk_mode <= 1'b0;
        end else begin
          mask <= mask | sel;
        end
        timer <= 32'(WINDOW_CYCLES);
      end else if (next_state == ST_SUSP_WAIT && state != ST_SUSP_WAIT) begin
        timer <= 32'(SUSP_CYC);
      end else if (next_state == ST_SECT && state != ST_SECT) begin
        if (state == ST_WIN) begin
          prog_phase <= 1'b1;
          pass <= 3'd0;
        end
        timer <= 32'(PHASE_CYCLES);
      end else if (!timer_done) begin
        timer <= timer - 32'd1;
      end else if (state == ST_BULK || state == ST_SECT) begin
        timer <= 32'(PHASE_CYCLES);
        if (prog_phase) begin
          prog_phase <= 1'b0;
        end else if (erase_fail) begin
          if (pass == 3'(PASSES - 1)) error_flag <= 1'b1;
          else pass <= pass + 3'd1;
        end
      end
      if (state == ST_SUSP && next_state == ST_READ) begin
        invalid <= invalid | mask;
      end else if (next_state == ST_READ && state != ST_READ) begin
        invalid <= invalid & ~mask;
      end
      if (next_state == ST_READ && state != ST_READ) bulk_mode <= 1'b0;
    end
  end

  // invalid data while suspended is the erased pattern, simplest to produce
  assign rdata = status_read ? status_byte :
    susp_read ? BYTE_ERASED : array_rdata;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata <= rdata;
    end
  end

  // array write strobe: only the program data cycle in ST_BYP_PRG, no erase-engine bytes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      array_we <= 1'b0;
      array_waddr <= '0;
      array_wdata <= 8'h00;
    end else begin
      array_we <= bus_wr && state == ST_BYP_PRG;
      array_waddr <= bus_addr;
      array_wdata <= bus_wdata;
    end
  end

  assign busy = erasing;
  assign sector_erase_mask = erasing ? mask : '0;
  assign sector_invalid = invalid;
endmodule // fecs_sequencer

/* File: fecs_seq_checker.sv */
// port checker for the flash erase command sequencer
// assumes one core_clk domain and async active-low rst_n
`timescale 1ns/1ps
module fecs_seq_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [fecs_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic busy,
  input wire logic [fecs_pkg::SECT_N-1:0] sector_erase_mask,
  input wire logic [fecs_pkg::SECT_N-1:0] sector_invalid,
  input wire logic array_we,
  input wire logic [fecs_pkg::ADDR_W-1:0] array_waddr,
  input wire logic [7:0] array_wdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_we_pulse; array_we |=> !array_we; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("we width");
  property p_we_src; array_we |-> $past(bus_wr) &&
    array_wdata == $past(bus_wdata) && array_waddr == $past(bus_addr);
  endproperty
  a_we_src: assert property (p_we_src) else $error("we source");
  // read data must not drift between reads
  property p_rd_hold; !$past(bus_rd) |-> $stable(bus_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_inv_src;
    |(sector_invalid & ~$past(sector_invalid)) |-> $past(bus_wr);
  endproperty
  a_inv_src: assert property (p_inv_src) else $error("invalid src");
  property p_busy_no_we; busy |-> !array_we; endproperty
  a_busy_no_we: assert property (p_busy_no_we) else $error("prg busy");
  property p_busy_rise; $rose(busy) |-> $past(bus_wr); endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy src");
  property p_mask_rise; $rose(|sector_erase_mask) |-> $past(bus_wr) &&
    $past(bus_wdata) inside {8'h10, 8'h30};
  endproperty
  a_mask_rise: assert property (p_mask_rise) else $error("mask src");
  property p_busy_mask; busy |-> |sector_erase_mask; endproperty
  a_busy_mask: assert property (p_busy_mask) else $error("no mask");
endmodule // fecs_seq_checker
bind fecs_sequencer fecs_seq_checker i_chk (.core_clk, .rst_n, .bus_addr,
  .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .busy, .sector_erase_mask,
  .sector_invalid, .array_we, .array_waddr, .array_wdata);

/* File: fecs_host_model.sv */
// bus master model of the microcontroller side
// assumes tasks are called in the time step of a rising core_clk edge
`timescale 1ns/1ps
module fecs_host_model (
  input wire logic core_clk,
  input wire logic [7:0] bus_rdata,
  output logic [fecs_pkg::ADDR_W-1:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] main_sector_select,
  output logic [3:0] boot_sector_select
);
  import fecs_pkg::*;
  // upper half of the map is boot space; selects are active high
  assign main_sector_select = bus_addr[15] ? 8'h00 : 8'h01 << bus_addr[14:12];
  assign boot_sector_select = bus_addr[15] ? 4'h1 << bus_addr[13:12] : 4'h0;
  initial begin
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    bus_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic idle(input int n);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_wdata <= ~bus_wdata;
    repeat (n) @(posedge core_clk);
  endtask
  // data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    bus_addr <= a;
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    @(posedge core_clk);
    d = bus_rdata;
  endtask
endmodule // fecs_host_model

/* File: fecs_sequencer_tb_top.sv */
// testbench for the flash erase command sequencer
// assumes fecs_host_model drives the bus; short window and phase counts
`timescale 1ns/1ps
module fecs_sequencer_tb_top;
  import fecs_pkg::*;
  logic core_clk, rst_n, erase_fail, bus_wr, bus_rd, busy, array_we;
  logic [15:0] bus_addr, array_waddr;
  logic [7:0] bus_wdata, bus_rdata, array_wdata, q, r, msel, arr;
  logic [3:0] bsel;
  logic [SECT_N-1:0] mask, inv;
  int n_fail, n_checks, k;
  // array content follows the address so the read path is exercised
  assign arr = bus_addr[7:0] ^ 8'h5a;
  fecs_host_model i_host (.core_clk, .bus_rdata, .bus_addr, .bus_wdata,
    .bus_wr, .bus_rd, .main_sector_select(msel), .boot_sector_select(bsel));
  fecs_sequencer #(.WINDOW_CYCLES(20), .PHASE_CYCLES(8), .PASSES(4)) i_dut (
    .core_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .main_sector_select(msel), .boot_sector_select(bsel),
    .array_rdata(arr), .erase_fail, .bus_rdata, .busy,
    .sector_erase_mask(mask), .sector_invalid(inv), .array_we,
    .array_waddr, .array_wdata);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] m, e);
    i_host.rd(a, q);
    cmp(q & m, e);
  endtask
  task automatic unl;
    i_host.wr(16'h0555, 8'haa);
    i_host.wr(16'h0aaa, 8'h55);
  endtask
  task automatic erase(input logic [15:0] a, input logic [7:0] c);
    unl();
    i_host.wr(16'h0555, 8'h80);
    unl();
    i_host.wr(a, c);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge core_clk);
    n_fail++;
    results();
  end
  initial begin
    rst_n = 1'b0;
    erase_fail = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    unl();
    i_host.wr(16'h0555, 8'h20);
    i_host.wr(16'h0000, 8'ha0);
    i_host.wr(16'h1234, 8'h3c);
    i_host.idle(0);
    @(negedge core_clk);
    cmp({array_we, array_wdata, array_waddr[6:0]}, 16'h9e34);
    @(posedge core_clk);
    i_host.wr(16'h0777, 8'h90);
    i_host.wr(16'h0333, 8'h00);
    i_host.wr(16'h0000, 8'ha0);
    i_host.wr(16'h1234, 8'h3c);
    i_host.idle(1);
    cmp(array_we, 1'b0);
    erase(16'h1000, 8'h30);
    rc(16'h1000, 8'ha8, 8'h00);
    i_host.rd(16'h1000, r);
    cmp(q[6] ^ r[6], 1'b1);
    i_host.idle(8);
    i_host.wr(16'h2000, 8'h30);
    i_host.idle(12);
    rc(16'h1000, 8'h08, 8'h00);
    i_host.idle(12);
    rc(16'h2000, 8'h88, 8'h08);
    i_host.wr(16'h1000, 8'hb0);
    i_host.idle(SUSP_CYC + 2);
    rc(16'h1000, 8'hff, 8'hff);
    rc(16'h5033, 8'hff, 8'h69);
    erase_fail <= 1'b1;
    i_host.wr(16'h1000, 8'h30);
    rc(16'h1000, 8'h08, 8'h08);
    k = 0;
    while (q[5] !== 1'b1 && k < 80) begin
      i_host.rd(16'h1000, q);
      k++;
    end
    cmp(q[5], 1'b1);
    i_host.wr(16'h0000, 8'hf0);
    erase_fail <= 1'b0;
    erase(16'h1000, 8'h30);
    i_host.idle(24);
    i_host.wr(16'h1000, 8'hb0);
    i_host.idle(8);
    i_host.wr(16'h1000, 8'hf0);
    i_host.idle(2);
    cmp(inv, 12'h002);
    erase(16'h1000, 8'h30);
    i_host.wr(16'h0000, 8'hf0);
    i_host.idle(2);
    cmp(busy, 1'b0);
    unl();
    i_host.wr(16'h0555, 8'h80);
    i_host.wr(16'h0555, 8'haa);
    i_host.wr(16'h0aaa, 8'h12);
    i_host.wr(16'h0555, 8'h10);
    i_host.idle(2);
    cmp(busy, 1'b0);
    erase(16'h0555, 8'h10);
    i_host.wr(16'h0000, 8'hf0);
    i_host.idle(2);
    cmp({busy, mask}, 13'h1fff);
    rc(16'h1000, 8'h80, 8'h00);
    i_host.idle(60);
    rc(16'h1000, 8'hff, 8'h5a);
    results();
  end
endmodule // fecs_sequencer_tb_top
